// ==== logic/dif_pkg.sv ====
// shared constants for the digital input function selector
package dif_pkg;
	// terminal count and code space
	localparam int NUM_TERM = 7;
	localparam int CODE_W = 8;
	localparam logic [7:0] CODE_MAX = 8'h9f;

	// decoded function codes
	localparam logic [7:0] CODE_THREE_WIRE = 8'h00;
	localparam logic [7:0] CODE_LOCAL_REMOTE = 8'h01;
	localparam logic [7:0] CODE_EXT_SELECT = 8'h02;
	localparam logic [7:0] CODE_THROUGH = 8'h0f;
	localparam logic [3:0] CODE_EXT_FAULT_HI = 4'h2;
	localparam logic [7:0] CODE_FWD_RUN = 8'h40;
	localparam logic [7:0] CODE_REV_RUN = 8'h41;

	// codes after a standard initialisation, terminal one first
	localparam logic [7:0] DEF_STD [NUM_TERM] = '{8'h40, 8'h41, 8'h24, 8'h14, 8'h03, 8'h04, 8'h06};
	// codes after a three-wire initialisation
	localparam logic [7:0] DEF_TW [NUM_TERM] = '{8'h40, 8'h41, 8'h24, 8'h14, 8'h00, 8'h03, 8'h04};

	// run source setting values and reference selection
	localparam int SRC_W = 2;
	localparam logic [1:0] RUN_SRC_TERMINALS = 2'h1;
	localparam int REF_W = 3;
	localparam logic [2:0] REF_OPERATOR = 3'h0;

	// timing
	localparam longint CLK_HZ = 25000000;
	localparam longint RUN_HOLD_MS = 50;
	localparam longint RUN_HOLD_CYC = RUN_HOLD_MS * (CLK_HZ / 1000);
	localparam longint FLASH_HALF_MS = 250;
	localparam longint FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam logic [1:0] SETTLE_CYC = 2'h3;
endpackage : dif_pkg

// ==== logic/dif_sync.sv ====
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module dif_sync #(
	parameter int W = 8
) (
	input wire logic clk, // system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic [W-1:0] din, // asynchronous inputs
	output logic [W-1:0] dout // synchronised inputs
);
	// first stage feeds only the second, nothing else looks at it
	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			logic meta;
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					meta <= 1'b0;
					dout[b] <= 1'b0;
				end else begin
					meta <= din[b];
					dout[b] <= meta;
				end
			end
		end
	endgenerate
endmodule : dif_sync

// ==== logic/dif_three_wire.sv ====
// three-wire run/stop latch with run hold qualification
`timescale 1ns/10ps
module dif_three_wire #(
	parameter longint HOLD_CYC = dif_pkg::RUN_HOLD_CYC
) (
	input wire logic clk, // system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic enable, // three-wire sequencing active
	input wire logic runIn, // run contact, high when closed
	input wire logic stopIn, // stop contact, high when closed
	output logic running // latched run state
);
	localparam int CW = $clog2(HOLD_CYC + 2);
	localparam logic [CW-1:0] HOLD = CW'(HOLD_CYC);
	logic [CW-1:0] holdCnt;

	// count closed cycles of the run contact, saturating past the limit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			holdCnt <= '0;
		end else if (!enable || !runIn) begin
			holdCnt <= '0;
		end else if (holdCnt <= HOLD) begin
			holdCnt <= holdCnt + 1'b1;
		end
	end

	// run latches between pulses; an open stop contact wins over run
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			running <= 1'b0;
		end else if (!enable || !stopIn) begin
			running <= 1'b0;
		end else if (runIn && holdCnt == HOLD) begin
			running <= 1'b1;
		end
	end

	a_start_delay: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(running) |-> $past(holdCnt) == HOLD && $past(runIn))
		else $error("three-wire run started before hold time");
	a_stop_release: assert property (@(posedge clk) disable iff (!arst_n)
		enable && !stopIn |=> !running)
		else $error("three-wire run kept after stop opened");
	a_run_latched: assert property (@(posedge clk) disable iff (!arst_n)
		running && enable && stopIn && !runIn |=> running)
		else $error("three-wire run lost without stop");
	c_tw_start: cover property (@(posedge clk) disable iff (!arst_n) $rose(running));
endmodule : dif_three_wire

// ==== logic/dif_select.sv ====
// multi-function digital input selector: codes, sequencing and source selection
// Contract
// - seven terminals each hold a function code, legal range up to 9F.
// - terminals one and two reject code 0; three to seven accept it.
// - standard init sets terminal one 40, three 24, four 14.
// - terminals five to seven get 3,4,6 standard or 0,3,4 three-wire.
// - code 40 is forward run, 41 reverse run, 20 to 2F external fault.
// - code 0 makes a direction input; terminal one runs, terminal two stops.
// - three-wire start needs run contact closed longer than 50 ms.
// - three-wire operation stops as soon as the stop contact opens.
// - three-wire direction is forward when open, reverse when closed.
// - run and stop are brief pulses; the run state is latched between them.
// - run active at power-up is refused and flashes unless accept setting set.
// - code 1 closed takes operator control, otherwise the external source.
// - operator local/remote key is ignored while code 1 is assigned.
// - local/remote indicator lights whenever local mode is selected.
// - local/remote does not change during run unless the setting permits.
// - code 2 open uses external source one, closed uses source two.
// - source one/two does not change during run unless the setting permits.
// - code F triggers nothing but its terminal state stays readable.
`timescale 1ns/10ps
module dif_select #(
	parameter longint RUN_HOLD_CYC = dif_pkg::RUN_HOLD_CYC,
	parameter longint FLASH_HALF_CYC = dif_pkg::FLASH_HALF_CYC
) (
	input wire logic clk, // 25 MHz system clock
	input wire logic arst_n, // asynchronous reset, active low
	input wire logic [6:0] terminalPin, // input terminals, high when closed
	input wire logic localRemoteKey, // operator local/remote key, high pressed
	input wire logic operatorRun, // operator run command
	input wire logic operatorReverse, // operator direction, high reverse
	input wire logic commRun, // run command from communication source
	input wire logic commReverse, // direction from communication source
	input wire logic initStrobe, // one-cycle pulse: load default codes
	input wire logic initThreeWire, // with initStrobe: three-wire defaults
	input wire logic codeWrEn, // one-cycle pulse: write a function code
	input wire logic [2:0] codeWrSel, // terminal index for write, 0 is terminal one
	input wire logic [7:0] codeWrData, // code to write
	input wire logic [2:0] codeRdSel, // terminal index for readback
	input wire logic powerUpRunAccept, // accept run active at power-up
	input wire logic sourceSwitchDuringRun, // permit source changes while running
	input wire logic [2:0] extSourceOneReference, // source one reference setting
	input wire logic [1:0] extSourceOneRun, // source one run setting
	input wire logic [2:0] extSourceTwoReference, // source two reference setting
	input wire logic [1:0] extSourceTwoRun, // source two run setting
	output logic runCmd, // drive run command
	output logic reverseDir, // drive direction, high reverse
	output logic localMode, // operator has control
	output logic localRemoteLed, // local indicator
	output logic extSourceTwo, // external source two in use
	output logic [2:0] activeRefSource, // reference source in use
	output logic runLedFlash, // run indicator flashing, power-up refusal
	output logic changePending, // a source change waits for stop
	output logic threeWireMode, // three-wire sequencing selected
	output logic extFaultActive, // an external fault input is closed
	output logic [6:0] terminalState, // synchronised terminal levels
	output logic codeReject, // one-cycle pulse: last write refused
	output logic [7:0] codeRdData // code of terminal codeRdSel
);
	localparam int N = dif_pkg::NUM_TERM;
	localparam int FW = $clog2(FLASH_HALF_CYC + 1);
	localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_HALF_CYC - 1);

	logic [N:0] syncIn;
	logic [N-1:0] termSync, termFunc, funcMask;
	logic [7:0] codeVec [N];
	logic [N-1:0] isDir, isLocRem, isExtSel, isFwd, isRev, isFault;
	logic keyPrev, keyRise, keyLocal, wrOk;
	logic dirClosed, locRemAssigned, locReq, srcReq, fwd2, rev2, threeWire;
	logic twRunning, twEnable, candRun, candRev, inhibit, armed;
	logic [1:0] selRun, settleCnt;
	logic [FW-1:0] flashCnt;

	// terminal and key pins pass the synchroniser before any logic reads them
	dif_sync #(.W(N + 1)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.din({localRemoteKey, terminalPin}),
		.dout(syncIn)
	);
	assign termSync = syncIn[N-1:0];
	assign keyRise = syncIn[N] && !keyPrev;

	// write legality: range check and no code 0 on the first two terminals
	assign wrOk = codeWrEn && (codeWrSel < 3'(N)) && (codeWrData <= dif_pkg::CODE_MAX)
		&& !(codeWrSel < 3'h2 && codeWrData == dif_pkg::CODE_THREE_WIRE);

	// per-terminal code storage and decode
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_term
			logic [7:0] code;
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					code <= dif_pkg::DEF_STD[i];
				end else if (initStrobe) begin
					code <= initThreeWire ? dif_pkg::DEF_TW[i] : dif_pkg::DEF_STD[i];
				end else if (wrOk && codeWrSel == 3'(i)) begin
					code <= codeWrData;
				end
			end
			assign codeVec[i] = code;
			// code F matches none of these, so the terminal is inert
			assign isDir[i] = code == dif_pkg::CODE_THREE_WIRE;
			assign isLocRem[i] = code == dif_pkg::CODE_LOCAL_REMOTE;
			assign isExtSel[i] = code == dif_pkg::CODE_EXT_SELECT;
			assign isFwd[i] = code == dif_pkg::CODE_FWD_RUN;
			assign isRev[i] = code == dif_pkg::CODE_REV_RUN;
			assign isFault[i] = code[7:4] == dif_pkg::CODE_EXT_FAULT_HI;
		end
	endgenerate

	// in three-wire mode terminals one and two are run/stop only
	assign threeWire = |isDir;
	assign funcMask = threeWire ? 7'h7c : 7'h7f;
	assign termFunc = termSync & funcMask;
	assign dirClosed = |(isDir & termFunc);
	assign locRemAssigned = |isLocRem;
	assign locReq = locRemAssigned ? |(isLocRem & termFunc) : keyLocal;
	assign srcReq = |(isExtSel & termFunc);
	assign fwd2 = |(isFwd & termFunc);
	assign rev2 = |(isRev & termFunc);
	assign selRun = extSourceTwo ? extSourceTwoRun : extSourceOneRun;
	assign twEnable = threeWire && !localMode && selRun == dif_pkg::RUN_SRC_TERMINALS;

	dif_three_wire #(.HOLD_CYC(RUN_HOLD_CYC)) u_tw (
		.clk(clk),
		.arst_n(arst_n),
		.enable(twEnable),
		.runIn(termSync[0]),
		.stopIn(termSync[1]),
		.running(twRunning)
	);

	// candidate run and direction from the source now in control
	always_comb begin
		candRun = 1'b0;
		candRev = 1'b0;
		if (localMode) begin
			candRun = operatorRun;
			candRev = operatorReverse;
		end else if (selRun == dif_pkg::RUN_SRC_TERMINALS) begin
			if (threeWire) begin
				candRun = twRunning;
				candRev = dirClosed;
			end else begin
				// both two-wire inputs closed reads as stop
				candRun = fwd2 ^ rev2;
				candRev = rev2;
			end
		end else begin
			candRun = commRun;
			candRev = commReverse;
		end
	end

	// operator key toggles local request only when no terminal owns it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			keyPrev <= 1'b0;
			keyLocal <= 1'b0;
		end else begin
			keyPrev <= syncIn[N];
			if (keyRise && !locRemAssigned) begin
				keyLocal <= !keyLocal;
			end
		end
	end

	// mode and source follow requests while stopped or when permitted;
	// otherwise the request waits and is taken up as soon as run drops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			localMode <= 1'b0;
			localRemoteLed <= 1'b0;
			extSourceTwo <= 1'b0;
		end else if (!runCmd || sourceSwitchDuringRun) begin
			localMode <= locReq;
			localRemoteLed <= locReq;
			extSourceTwo <= srcReq;
		end
	end

	// status outputs, all registered
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			changePending <= 1'b0;
			threeWireMode <= 1'b0;
			extFaultActive <= 1'b0;
			terminalState <= '0;
			codeReject <= 1'b0;
			codeRdData <= '0;
			activeRefSource <= dif_pkg::REF_OPERATOR;
		end else begin
			changePending <= (locReq != localMode) || (srcReq != extSourceTwo);
			threeWireMode <= threeWire;
			extFaultActive <= |(isFault & termFunc);
			terminalState <= termSync;
			codeReject <= codeWrEn && !wrOk;
			codeRdData <= (codeRdSel < 3'(N)) ? codeVec[codeRdSel] : 8'h00;
			if (localMode) begin
				activeRefSource <= dif_pkg::REF_OPERATOR;
			end else begin
				activeRefSource <= extSourceTwo ? extSourceTwoReference : extSourceOneReference;
			end
		end
	end

	// give the synchronisers time to fill before judging the power-up state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			settleCnt <= '0;
			armed <= 1'b0;
		end else if (!armed) begin
			settleCnt <= settleCnt + 1'b1;
			armed <= settleCnt == dif_pkg::SETTLE_CYC;
		end
	end

	// a run already present when armed is refused until it is withdrawn
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inhibit <= 1'b0;
		end else if (!armed && settleCnt == dif_pkg::SETTLE_CYC) begin
			inhibit <= candRun && !powerUpRunAccept;
		end else if (inhibit && !candRun) begin
			inhibit <= 1'b0;
		end
	end

	// run command and direction to the drive
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			runCmd <= 1'b0;
			reverseDir <= 1'b0;
		end else begin
			runCmd <= armed && candRun && !inhibit;
			reverseDir <= candRev;
		end
	end

	// run indicator flashes while a power-up run is refused
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flashCnt <= '0;
			runLedFlash <= 1'b0;
		end else if (!inhibit) begin
			flashCnt <= '0;
			runLedFlash <= 1'b0;
		end else if (flashCnt == FLASH_LAST) begin
			flashCnt <= '0;
			runLedFlash <= !runLedFlash;
		end else begin
			flashCnt <= flashCnt + 1'b1;
		end
	end

	a_code_range: assert property (@(posedge clk) disable iff (!arst_n)
		codeWrEn && !initStrobe && codeWrData > dif_pkg::CODE_MAX |=> codeReject
		&& $stable({codeVec[0], codeVec[1], codeVec[2], codeVec[3], codeVec[4], codeVec[5], codeVec[6]}))
		else $error("out of range code accepted");
	a_first_no_zero: assert property (@(posedge clk) disable iff (!arst_n)
		codeWrEn && codeWrSel < 3'h2 && codeWrData == 8'h00 |=> codeReject)
		else $error("code 0 accepted on terminal one or two");
	a_init_std: assert property (@(posedge clk) disable iff (!arst_n)
		initStrobe && !initThreeWire |=> codeVec[0] == 8'h40 && codeVec[2] == 8'h24 && codeVec[3] == 8'h14)
		else $error("standard defaults wrong");
	a_init_three: assert property (@(posedge clk) disable iff (!arst_n)
		initStrobe && initThreeWire |=> codeVec[4] == 8'h00 && codeVec[5] == 8'h03 && codeVec[6] == 8'h04)
		else $error("three-wire defaults wrong");
	a_fwd_two_wire: assert property (@(posedge clk) disable iff (!arst_n)
		armed && !inhibit && !localMode && !threeWire && selRun == dif_pkg::RUN_SRC_TERMINALS
		&& fwd2 && !rev2 |=> runCmd && !reverseDir)
		else $error("two-wire forward not obeyed");
	a_dir_reverse: assert property (@(posedge clk) disable iff (!arst_n)
		twEnable && dirClosed |=> reverseDir)
		else $error("three-wire direction not reverse");
	a_key_ignored: assert property (@(posedge clk) disable iff (!arst_n)
		locRemAssigned |=> $stable(keyLocal))
		else $error("operator key acted while terminal owns mode");
	a_local_led: assert property (@(posedge clk) disable iff (!arst_n)
		localRemoteLed == localMode)
		else $error("local indicator disagrees with mode");
	a_hold_in_run: assert property (@(posedge clk) disable iff (!arst_n)
		runCmd && !sourceSwitchDuringRun |=> $stable(localMode) && $stable(extSourceTwo))
		else $error("source changed during run");
	a_pending_apply: assert property (@(posedge clk) disable iff (!arst_n)
		!runCmd && srcReq != extSourceTwo |=> extSourceTwo == $past(srcReq))
		else $error("pending source change not applied at stop");
	a_powerup_block: assert property (@(posedge clk) disable iff (!arst_n)
		inhibit |=> !runCmd)
		else $error("run issued during power-up refusal");

	c_run_start: cover property (@(posedge clk) disable iff (!arst_n) $rose(runCmd));
	c_local_take: cover property (@(posedge clk) disable iff (!arst_n) $rose(localMode));
	c_pending: cover property (@(posedge clk) disable iff (!arst_n) runCmd && changePending);
	c_refused: cover property (@(posedge clk) disable iff (!arst_n) $rose(runLedFlash));
endmodule : dif_select

// ==== sim/dif_switch_model.sv ====
// contact model of the switches wired to the seven input terminals
`timescale 1ns/10ps
module dif_switch_model (
	input wire logic clk, // system clock
	output logic [6:0] terminalPin // contact levels, high when closed
);
	// every contact starts open; an open contact reads low, never the last level
	initial begin
		terminalPin = 7'h00;
	end

	// contacts move only at the falling edge so the design never samples a change mid-edge
	task automatic setContact(input int idx, input logic closed);
		@(negedge clk);
		terminalPin[idx] = closed;
	endtask : setContact

	// momentary push button: closed for a few cycles, then released
	task automatic pulse(input int idx, input int cyc);
		setContact(idx, 1'b1);
		repeat (cyc) @(negedge clk);
		terminalPin[idx] = 1'b0;
	endtask : pulse
endmodule : dif_switch_model

// ==== sim/tb_top.sv ====
// self-checking bench for the digital input function selector
`timescale 1ns/10ps
module tb_top;
	// short counts keep the run brief; expectations follow from these values
	localparam longint HOLD = 10;
	localparam longint FLASH = 4;
	localparam int SETTLE = 6;
	localparam int LIMIT = 5000;
	localparam logic [7:0] STD_CODES [7] = '{8'h40, 8'h41, 8'h24, 8'h14, 8'h03, 8'h04, 8'h06};
	localparam logic [7:0] TW_CODES [7] = '{8'h40, 8'h41, 8'h24, 8'h14, 8'h00, 8'h03, 8'h04};

	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] terminalPin;
	logic localRemoteKey = 1'b0;
	logic operatorRun = 1'b0;
	logic commRun = 1'b0;
	logic [1:0] extSourceTwoRun = 2'h1;
	logic initStrobe = 1'b0;
	logic initThreeWire = 1'b0;
	logic codeWrEn = 1'b0;
	logic [2:0] codeWrSel = 3'h0;
	logic [7:0] codeWrData = 8'h00;
	logic [2:0] codeRdSel = 3'h0;
	logic powerUpRunAccept = 1'b0;
	logic sourceSwitchDuringRun = 1'b0;
	logic runCmd, reverseDir, localMode, localRemoteLed, extSourceTwo, runLedFlash;
	logic changePending, threeWireMode, extFaultActive, codeReject;
	logic [2:0] activeRefSource;
	logic [6:0] terminalState;
	logic [7:0] codeRdData;
	int nMismatch = 0;
	int numChecks = 0;
	int cycles = 0;
	logic flashSeen;

	always #20 clk = ~clk;

	dif_switch_model dif_switch_model_inst (.clk(clk), .terminalPin(terminalPin));

	dif_select #(.RUN_HOLD_CYC(HOLD), .FLASH_HALF_CYC(FLASH)) dif_select_inst (
		.clk(clk), .arst_n(arst_n), .terminalPin(terminalPin), .localRemoteKey(localRemoteKey),
		.operatorRun(operatorRun), .operatorReverse(1'b0), .commRun(commRun), .commReverse(1'b0),
		.initStrobe(initStrobe), .initThreeWire(initThreeWire), .codeWrEn(codeWrEn),
		.codeWrSel(codeWrSel), .codeWrData(codeWrData), .codeRdSel(codeRdSel),
		.powerUpRunAccept(powerUpRunAccept), .sourceSwitchDuringRun(sourceSwitchDuringRun),
		.extSourceOneReference(3'h3), .extSourceOneRun(2'h1), .extSourceTwoReference(3'h5),
		.extSourceTwoRun(extSourceTwoRun), .runCmd(runCmd), .reverseDir(reverseDir), .localMode(localMode),
		.localRemoteLed(localRemoteLed), .extSourceTwo(extSourceTwo), .activeRefSource(activeRefSource),
		.runLedFlash(runLedFlash), .changePending(changePending), .threeWireMode(threeWireMode),
		.extFaultActive(extFaultActive), .terminalState(terminalState), .codeReject(codeReject),
		.codeRdData(codeRdData)
	);

	task automatic testDone();
		if (nMismatch == 0 && numChecks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : testDone

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// contact change followed by the synchroniser and output latency
	task automatic contact(input int idx, input logic closed);
		dif_switch_model_inst.setContact(idx, closed);
		cyc(SETTLE);
	endtask : contact

	// one write; the refusal pulse stands in the cycle after the taking edge
	task automatic writeCode(input logic [2:0] sel, input logic [7:0] data, input logic expRej);
		@(negedge clk);
		codeWrEn = 1'b1;
		codeWrSel = sel;
		codeWrData = data;
		@(negedge clk);
		codeWrEn = 1'b0;
		check("codeReject", 8'(codeReject), 8'(expRej));
	endtask : writeCode

	task automatic readCode(input logic [2:0] sel, input logic [7:0] exp);
		@(negedge clk);
		codeRdSel = sel;
		cyc(2);
		check("codeRdData", codeRdData, exp);
	endtask : readCode

	task automatic loadDefaults(input logic threeWire);
		@(negedge clk);
		initStrobe = 1'b1;
		initThreeWire = threeWire;
		@(negedge clk);
		initStrobe = 1'b0;
		initThreeWire = 1'b0;
	endtask : loadDefaults

	task automatic doReset();
		@(negedge clk);
		arst_n = 1'b0;
		cyc(16);
		arst_n = 1'b1;
		cyc(10);
	endtask : doReset

	// a hang is cut short here and counted as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			nMismatch++;
			testDone();
		end
	end

	initial begin
		cyc(16);
		arst_n = 1'b1;
		cyc(SETTLE);
		for (int i = 0; i < 7; i++) begin
			readCode(3'(i), STD_CODES[i]);
		end
		// refused writes leave the stored code alone
		writeCode(3'h0, 8'h00, 1'b1);
		writeCode(3'h1, 8'h00, 1'b1);
		readCode(3'h0, 8'h40);
		writeCode(3'h2, 8'h00, 1'b0);
		readCode(3'h2, 8'h00);
		writeCode(3'h3, 8'ha0, 1'b1);
		writeCode(3'h7, 8'h0f, 1'b1);
		writeCode(3'h4, 8'h9f, 1'b0);
		readCode(3'h4, 8'h9f);
		loadDefaults(1'b1);
		for (int i = 4; i < 7; i++) begin
			readCode(3'(i), TW_CODES[i]);
		end
		check("threeWireMode", 8'(threeWireMode), 8'h01);
		// three-wire: a push shorter than the hold is ignored, a long one latches
		contact(1, 1'b1);
		dif_switch_model_inst.pulse(0, 8);
		cyc(SETTLE);
		check("runCmd short push", 8'(runCmd), 8'h00);
		dif_switch_model_inst.pulse(0, 30);
		cyc(SETTLE);
		check("runCmd latched", 8'(runCmd), 8'h01);
		contact(4, 1'b1);
		check("reverseDir closed", 8'(reverseDir), 8'h01);
		contact(4, 1'b0);
		check("reverseDir open", 8'(reverseDir), 8'h00);
		contact(1, 1'b0);
		check("runCmd stop", 8'(runCmd), 8'h00);
		// two-wire run, both directions at once means stop, external fault
		loadDefaults(1'b0);
		contact(2, 1'b1);
		check("extFaultActive", 8'(extFaultActive), 8'h01);
		contact(2, 1'b0);
		contact(0, 1'b1);
		check("runCmd fwd", {6'h00, runCmd, reverseDir}, 8'h02);
		contact(1, 1'b1);
		check("runCmd both", 8'(runCmd), 8'h00);
		contact(0, 1'b0);
		check("runCmd rev", {6'h00, runCmd, reverseDir}, 8'h03);
		contact(1, 1'b0);
		// local/remote terminal overrides the operator key
		writeCode(3'h5, 8'h01, 1'b0);
		contact(5, 1'b1);
		check("local", {4'h0, localMode, localRemoteLed, 2'h0}, 8'h0c);
		check("activeRefSource local", 8'(activeRefSource), 8'h00);
		@(negedge clk);
		operatorRun = 1'b1;
		localRemoteKey = 1'b1;
		cyc(SETTLE);
		check("runCmd operator", 8'(runCmd), 8'h01);
		check("localMode key", 8'(localMode), 8'h01);
		operatorRun = 1'b0;
		localRemoteKey = 1'b0;
		contact(5, 1'b0);
		check("remote", {4'h0, localMode, localRemoteLed, 2'h0}, 8'h00);
		check("activeRefSource remote", 8'(activeRefSource), 8'h03);
		// a mode change during run waits for the stop
		contact(0, 1'b1);
		contact(5, 1'b1);
		check("local held", {6'h00, localMode, changePending}, 8'h01);
		contact(0, 1'b0);
		check("local applied", 8'(localMode), 8'h01);
		contact(5, 1'b0);
		// with code 1 gone the key owns the mode; the earlier press must have left it alone
		writeCode(3'h5, 8'h0f, 1'b0);
		cyc(SETTLE);
		check("key press ignored", 8'(localMode), 8'h00);
		localRemoteKey = 1'b1;
		cyc(SETTLE);
		check("key to local", 8'(localMode), 8'h01);
		localRemoteKey = 1'b0;
		cyc(SETTLE);
		localRemoteKey = 1'b1;
		cyc(SETTLE);
		check("key to remote", 8'(localMode), 8'h00);
		localRemoteKey = 1'b0;
		// external source one/two selection
		writeCode(3'h6, 8'h02, 1'b0);
		contact(6, 1'b1);
		check("source two", {4'h0, extSourceTwo, activeRefSource}, 8'h0d);
		contact(6, 1'b0);
		check("source one", {4'h0, extSourceTwo, activeRefSource}, 8'h03);
		// source two takes its run command from communication instead of the terminals
		extSourceTwoRun = 2'h2;
		commRun = 1'b1;
		contact(6, 1'b1);
		check("runCmd comm", 8'(runCmd), 8'h01);
		commRun = 1'b0;
		cyc(SETTLE);
		check("runCmd comm stop", 8'(runCmd), 8'h00);
		contact(6, 1'b0);
		extSourceTwoRun = 2'h1;
		sourceSwitchDuringRun = 1'b1;
		contact(0, 1'b1);
		contact(6, 1'b1);
		check("source two in run", 8'(extSourceTwo), 8'h01);
		sourceSwitchDuringRun = 1'b0;
		contact(6, 1'b0);
		check("source held", {6'h00, extSourceTwo, changePending}, 8'h03);
		contact(0, 1'b0);
		check("source applied", 8'(extSourceTwo), 8'h00);
		// through mode: level readable, no function
		writeCode(3'h3, 8'h0f, 1'b0);
		contact(3, 1'b1);
		check("terminalState", 8'(terminalState), 8'h08);
		check("through no run", {6'h00, runCmd, extFaultActive}, 8'h00);
		contact(3, 1'b0);
		// run contact already closed at power-up
		dif_switch_model_inst.setContact(0, 1'b1);
		doReset();
		check("runCmd refused", 8'(runCmd), 8'h00);
		flashSeen = runLedFlash;
		cyc(int'(FLASH));
		check("runLedFlash toggles", 8'(runLedFlash ^ flashSeen), 8'h01);
		// withdrawing the run ends the refusal, a fresh run is then obeyed
		contact(0, 1'b0);
		check("runLedFlash cleared", 8'(runLedFlash), 8'h00);
		contact(0, 1'b1);
		check("runCmd after withdraw", 8'(runCmd), 8'h01);
		powerUpRunAccept = 1'b1;
		doReset();
		check("runCmd accepted", 8'(runCmd), 8'h01);
		testDone();
	end
endmodule : tb_top
